//--- hw/dbcc_pkg.sv
// Shared constants and types for the dual bridge chop control block
package dbcc_pkg;

  localparam int CLK_MHZ       = 125;
  // Printed times, in their own units
  localparam int OFF_TIME_NS   = 25000;
  localparam int DEAD_TIME_NS  = 500;
  localparam int BLANK_TIME_NS = 3000;
  localparam int STANDBY_US    = 1000;
  localparam int FAST_PCT      = 50;
  localparam int TRIP_GAIN     = 10;
  // Derived cycle counts
  localparam int OFF_CYC   = (OFF_TIME_NS * CLK_MHZ) / 1000;
  localparam int DEAD_CYC  = (DEAD_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int BLANK_CYC = (BLANK_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int FAST_CYC  = (OFF_CYC * FAST_PCT) / 100;
  localparam int STANDBY_CYC = STANDBY_US * CLK_MHZ;
  localparam int CNT_W     = 18;

  typedef enum logic [2:0] {
    DBCC_COAST,
    DBCC_DRIVE,
    DBCC_FAST,
    DBCC_DEAD,
    DBCC_SLOW,
    DBCC_BRAKE
  } dbcc_state_t;

endpackage

//--- hw/dbcc_bridge.sv
// One full bridge: drive decode, trip, mixed decay sequencing
`timescale 1ns/100ps
module dbcc_bridge #(
  parameter int OFF_CYC   = dbcc_pkg::OFF_CYC,
  parameter int FAST_CYC  = dbcc_pkg::FAST_CYC,
  parameter int DEAD_CYC  = dbcc_pkg::DEAD_CYC,
  parameter int BLANK_CYC = dbcc_pkg::BLANK_CYC
) (
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  input  wire logic       ctl_first_in,
  input  wire logic       ctl_second_in,
  input  wire logic       trip_in,
  input  wire logic       zero_cur_in,
  input  wire logic       enable_in,
  output logic            leg_first_out,
  output logic            leg_first_oe_out,
  output logic            leg_second_out,
  output logic            leg_second_oe_out,
  output logic            sync_rect_out,
  output logic            in_decay_out
);

  dbcc_pkg::dbcc_state_t  st_r;
  dbcc_pkg::dbcc_state_t  st_nxt;
  logic [dbcc_pkg::CNT_W-1:0] cnt_r;
  logic [dbcc_pkg::CNT_W-1:0] cnt_nxt;
  logic                   fwd_r;
  logic                   fwd_nxt;
  logic                   zc_r;
  logic                   zc_nxt;
  logic                   lf;
  logic                   lfe;
  logic                   ls;
  logic                   lse;
  logic                   sr;
  logic                   drive_req;
  logic [dbcc_pkg::CNT_W-1:0] fast_run_r;
  logic [dbcc_pkg::CNT_W-1:0] fast_run_nxt;

  assign drive_req = ctl_first_in ^ ctl_second_in;

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    fwd_nxt = fwd_r;
    zc_nxt  = zc_r;
    if (cnt_r != '0)
    begin
      cnt_nxt = cnt_r - 1'b1;
    end
    unique case (st_r)
      dbcc_pkg::DBCC_COAST, dbcc_pkg::DBCC_BRAKE:
      begin
        if (drive_req)
        begin
          st_nxt  = dbcc_pkg::DBCC_DRIVE;
          fwd_nxt = ctl_first_in;
          cnt_nxt = dbcc_pkg::CNT_W'(BLANK_CYC);
        end
        else if (ctl_first_in && ctl_second_in)
        begin
          st_nxt = dbcc_pkg::DBCC_BRAKE;
        end
        else
        begin
          st_nxt = dbcc_pkg::DBCC_COAST;
        end
      end
      dbcc_pkg::DBCC_DRIVE:
      begin
        if (!drive_req || fwd_r != ctl_first_in)
        begin
          st_nxt = dbcc_pkg::DBCC_COAST;
        end
        else if (trip_in && cnt_r == '0)
        begin
          // Blanking hides switching spikes on the sense line
          st_nxt  = dbcc_pkg::DBCC_FAST;
          cnt_nxt = dbcc_pkg::CNT_W'(FAST_CYC - 1);
          zc_nxt  = 1'b0;
        end
      end
      dbcc_pkg::DBCC_FAST:
      begin
        if (cnt_r == '0)
        begin
          st_nxt  = dbcc_pkg::DBCC_DEAD;
          cnt_nxt = dbcc_pkg::CNT_W'(DEAD_CYC - 1);
        end
      end
      dbcc_pkg::DBCC_DEAD:
      begin
        if (cnt_r == '0)
        begin
          st_nxt  = dbcc_pkg::DBCC_SLOW;
          cnt_nxt = dbcc_pkg::CNT_W'(OFF_CYC - FAST_CYC - DEAD_CYC - 1);
        end
      end
      dbcc_pkg::DBCC_SLOW:
      begin
        if (cnt_r == '0)
        begin
          if (drive_req && fwd_r == ctl_first_in)
          begin
            st_nxt  = dbcc_pkg::DBCC_DRIVE;
            cnt_nxt = dbcc_pkg::CNT_W'(BLANK_CYC);
          end
          else
          begin
            st_nxt = dbcc_pkg::DBCC_COAST;
          end
        end
      end
      default:
      begin
        st_nxt = dbcc_pkg::DBCC_COAST;
      end
    endcase
    if (zero_cur_in && (st_r == dbcc_pkg::DBCC_FAST ||
                        st_r == dbcc_pkg::DBCC_SLOW))
    begin
      zc_nxt = 1'b1;
    end
    if (!enable_in)
    begin
      st_nxt  = dbcc_pkg::DBCC_COAST;
      cnt_nxt = '0;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      st_r  <= dbcc_pkg::DBCC_COAST;
      cnt_r <= '0;
      fwd_r <= 1'b0;
      zc_r  <= 1'b0;
    end
    else
    begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      fwd_r <= fwd_nxt;
      zc_r  <= zc_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output legs; the held-low leg keeps its sink on through the slow decay
  always_comb
  begin
    lf  = 1'b0;
    lfe = 1'b0;
    ls  = 1'b0;
    lse = 1'b0;
    sr  = 1'b0;
    unique case (st_r)
      dbcc_pkg::DBCC_DRIVE:
      begin
        lf  = fwd_r;
        ls  = !fwd_r;
        lfe = 1'b1;
        lse = 1'b1;
      end
      dbcc_pkg::DBCC_BRAKE:
      begin
        lfe = 1'b1;
        lse = 1'b1;
      end
      dbcc_pkg::DBCC_FAST:
      begin
        // Fast decay: legs reversed against the drive direction
        sr  = !zc_r;
        lf  = !fwd_r;
        ls  = fwd_r;
        lfe = sr;
        lse = sr;
      end
      dbcc_pkg::DBCC_SLOW:
      begin
        sr  = !zc_r;
        lfe = fwd_r ? 1'b1 : sr;
        lse = fwd_r ? sr : 1'b1;
      end
      default:
      begin
        lf = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    leg_first_out     = lf;
    leg_first_oe_out  = lfe;
    leg_second_out    = ls;
    leg_second_oe_out = lse;
    sync_rect_out     = sr;
    in_decay_out      = (st_r == dbcc_pkg::DBCC_FAST) ||
                        (st_r == dbcc_pkg::DBCC_DEAD) ||
                        (st_r == dbcc_pkg::DBCC_SLOW);
  end

  ////////////////////////////////////////////////////////////////////////
  // Checker helper: cycles spent so far in the current fast decay;
  // a counter, as the off-time is far beyond any delay range
  always_comb
  begin
    fast_run_nxt = '0;
    if (st_r == dbcc_pkg::DBCC_FAST)
    begin
      fast_run_nxt = fast_run_r + 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      fast_run_r <= '0;
    end
    else
    begin
      fast_run_r <= fast_run_nxt;
    end
  end

  chk_dead_quiet: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    st_r == dbcc_pkg::DBCC_DEAD |-> !lfe && !lse && !sr)
    else $error("drivers on during dead time");

  chk_fwd_drive: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    st_r == dbcc_pkg::DBCC_DRIVE && fwd_r |-> lf && !ls && lfe && lse)
    else $error("forward drive wrong");

  chk_trip_decay: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    st_r == dbcc_pkg::DBCC_DRIVE && trip_in && cnt_r == '0 && enable_in &&
    drive_req && fwd_r == ctl_first_in
    |=> st_r == dbcc_pkg::DBCC_FAST)
    else $error("trip did not start decay");

  chk_fast_len: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    st_r == dbcc_pkg::DBCC_FAST |-> fast_run_r < dbcc_pkg::CNT_W'(FAST_CYC))
    else $error("fast decay too long");

  chk_coast_z: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    st_r == dbcc_pkg::DBCC_COAST |-> !lfe && !lse)
    else $error("coast not high impedance");

  chk_zc_off: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    zc_r |-> !sr)
    else $error("rectifier on after zero current");

  chk_disable: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    !enable_in |=> st_r == dbcc_pkg::DBCC_COAST)
    else $error("disabled bridge still active");

endmodule

//--- hw/dbcc_top.sv
// Dual bridge chop control top: sync, standby, faults, two bridges
`timescale 1ns/100ps
// Summary of operation
// - Each bridge follows only its own input pair and own regulation.
// - Inputs one-zero drive forward; zero-one drive reverse.
// - Tenfold sense above reference trips the bridge into decay.
// - Trip in forward holds leg A low; reverse holds leg B low.
// - Both inputs high brake with both legs low.
// - Both inputs low leave both legs high impedance.
// - All four inputs low over 1 ms enters standby, disabling supplies.
// - Output short latches a fault for that channel and disables it.
// - Fault clears only on standby exit or reset.
// - Over-temperature flag disables all outputs until it clears.
// - Supply-low flag holds all drivers off until it clears.
// - Decay turns on recirculation switches, synchronous rectification.
// - Zero current during decay turns synchronous rectification off.
// - Fast decay for half the off-time, then slow decay.
// - Fast-to-slow change forces all drivers off for dead time.
module dbcc_top #(
  parameter int OFF_CYC     = dbcc_pkg::OFF_CYC,
  parameter int FAST_CYC    = dbcc_pkg::FAST_CYC,
  parameter int DEAD_CYC    = dbcc_pkg::DEAD_CYC,
  parameter int BLANK_CYC   = dbcc_pkg::BLANK_CYC,
  parameter int STANDBY_CYC = dbcc_pkg::STANDBY_CYC
) (
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  input  wire logic       bridge_a_ctl_first_in,
  input  wire logic       bridge_a_ctl_second_in,
  input  wire logic       bridge_b_ctl_first_in,
  input  wire logic       bridge_b_ctl_second_in,
  input  wire logic       bridge_a_trip_in,
  input  wire logic       bridge_b_trip_in,
  input  wire logic       bridge_a_zero_cur_in,
  input  wire logic       bridge_b_zero_cur_in,
  input  wire logic       bridge_a_short_in,
  input  wire logic       bridge_b_short_in,
  input  wire logic       over_temp_in,
  input  wire logic       supply_low_lockout_in,
  output logic            bridge_a_leg_first_out,
  output logic            bridge_a_leg_first_oe_out,
  output logic            bridge_a_leg_second_out,
  output logic            bridge_a_leg_second_oe_out,
  output logic            bridge_b_leg_first_out,
  output logic            bridge_b_leg_first_oe_out,
  output logic            bridge_b_leg_second_out,
  output logic            bridge_b_leg_second_oe_out,
  output logic            bridge_a_sync_rect_out,
  output logic            bridge_b_sync_rect_out,
  output logic            pump_enable_out,
  output logic            regulator_enable_out,
  output logic            standby_out,
  output logic [1:0]      overcurrent_fault_latch_out
);

  localparam int NSYNC = 12;

  logic [NSYNC-1:0]       meta_r;
  logic [NSYNC-1:0]       sync_r;
  logic [NSYNC-1:0]       raw;
  logic                   a_f;
  logic                   a_s;
  logic                   b_f;
  logic                   b_s;
  logic                   a_trip;
  logic                   b_trip;
  logic                   a_zc;
  logic                   b_zc;
  logic                   a_short;
  logic                   b_short;
  logic                   hot;
  logic                   low_sup;
  logic [dbcc_pkg::CNT_W-1:0] idle_cnt_r;
  logic [dbcc_pkg::CNT_W-1:0] idle_cnt_nxt;
  logic                   stby_r;
  logic                   stby_nxt;
  logic [1:0]             fault_r;
  logic [1:0]             fault_nxt;
  logic                   all_low;
  logic                   global_ok;
  logic                   a_en;
  logic                   b_en;
  logic                   a_dec;
  logic                   b_dec;

  ////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for every pin and analog flag
  assign raw = {supply_low_lockout_in, over_temp_in,
                bridge_b_short_in, bridge_a_short_in,
                bridge_b_zero_cur_in, bridge_a_zero_cur_in,
                bridge_b_trip_in, bridge_a_trip_in,
                bridge_b_ctl_second_in, bridge_b_ctl_first_in,
                bridge_a_ctl_second_in, bridge_a_ctl_first_in};

  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= raw;
      sync_r <= meta_r;
    end
  end

  assign a_f     = sync_r[0];
  assign a_s     = sync_r[1];
  assign b_f     = sync_r[2];
  assign b_s     = sync_r[3];
  assign a_trip  = sync_r[4];
  assign b_trip  = sync_r[5];
  assign a_zc    = sync_r[6];
  assign b_zc    = sync_r[7];
  assign a_short = sync_r[8];
  assign b_short = sync_r[9];
  assign hot     = sync_r[10];
  assign low_sup = sync_r[11];

  ////////////////////////////////////////////////////////////////////////
  // Standby timer and per-channel fault latches
  assign all_low = !a_f && !a_s && !b_f && !b_s;

  always_comb
  begin
    idle_cnt_nxt = idle_cnt_r;
    stby_nxt     = stby_r;
    fault_nxt    = fault_r;
    if (!all_low)
    begin
      idle_cnt_nxt = '0;
      stby_nxt     = 1'b0;
      if (stby_r)
      begin
        // Wake clears faults; a short this cycle re-latches below
        fault_nxt = 2'h0;
      end
    end
    else if (idle_cnt_r == dbcc_pkg::CNT_W'(STANDBY_CYC))
    begin
      stby_nxt = 1'b1;
    end
    else
    begin
      idle_cnt_nxt = idle_cnt_r + 1'b1;
    end
    // Set wins over the wake clear
    if (a_short)
    begin
      fault_nxt[0] = 1'b1;
    end
    if (b_short)
    begin
      fault_nxt[1] = 1'b1;
    end
  end

  always_ff @(posedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      idle_cnt_r <= '0;
      stby_r     <= 1'b0;
      fault_r    <= 2'h0;
    end
    else
    begin
      idle_cnt_r <= idle_cnt_nxt;
      stby_r     <= stby_nxt;
      fault_r    <= fault_nxt;
    end
  end

  assign global_ok = !hot && !low_sup && !stby_r;
  assign a_en = global_ok && !fault_r[0];
  assign b_en = global_ok && !fault_r[1];

  ////////////////////////////////////////////////////////////////////////
  dbcc_bridge #(
    .OFF_CYC   (OFF_CYC),
    .FAST_CYC  (FAST_CYC),
    .DEAD_CYC  (DEAD_CYC),
    .BLANK_CYC (BLANK_CYC)
  ) u_bridge_a (
    .mclk_in           (mclk_in),
    .resetn_in         (resetn_in),
    .ctl_first_in      (a_f),
    .ctl_second_in     (a_s),
    .trip_in           (a_trip),
    .zero_cur_in       (a_zc),
    .enable_in         (a_en),
    .leg_first_out     (bridge_a_leg_first_out),
    .leg_first_oe_out  (bridge_a_leg_first_oe_out),
    .leg_second_out    (bridge_a_leg_second_out),
    .leg_second_oe_out (bridge_a_leg_second_oe_out),
    .sync_rect_out     (bridge_a_sync_rect_out),
    .in_decay_out      (a_dec)
  );

  dbcc_bridge #(
    .OFF_CYC   (OFF_CYC),
    .FAST_CYC  (FAST_CYC),
    .DEAD_CYC  (DEAD_CYC),
    .BLANK_CYC (BLANK_CYC)
  ) u_bridge_b (
    .mclk_in           (mclk_in),
    .resetn_in         (resetn_in),
    .ctl_first_in      (b_f),
    .ctl_second_in     (b_s),
    .trip_in           (b_trip),
    .zero_cur_in       (b_zc),
    .enable_in         (b_en),
    .leg_first_out     (bridge_b_leg_first_out),
    .leg_first_oe_out  (bridge_b_leg_first_oe_out),
    .leg_second_out    (bridge_b_leg_second_out),
    .leg_second_oe_out (bridge_b_leg_second_oe_out),
    .sync_rect_out     (bridge_b_sync_rect_out),
    .in_decay_out      (b_dec)
  );

  // Controller must allow pump settle time after wake
  assign pump_enable_out      = !stby_r;
  assign regulator_enable_out = !stby_r;
  assign standby_out          = stby_r;
  assign overcurrent_fault_latch_out = fault_r;

  ////////////////////////////////////////////////////////////////////////
  chk_fault_off: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    fault_r[0] |=> !bridge_a_leg_first_oe_out && !bridge_a_leg_second_oe_out)
    else $error("faulted channel still driving");

  chk_fault_hold: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    fault_r != 2'h0 && !stby_r
    |=> (fault_r & $past(fault_r)) == $past(fault_r))
    else $error("fault cleared without standby exit");

  chk_hot_off: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    hot |=> !bridge_a_leg_first_oe_out && !bridge_b_leg_second_oe_out)
    else $error("outputs on while hot");

  chk_uv_off: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    low_sup |=> !bridge_b_leg_first_oe_out && !bridge_a_leg_second_oe_out)
    else $error("outputs on under low supply");

  chk_standby_on: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    stby_r |-> !pump_enable_out && !regulator_enable_out)
    else $error("supplies enabled in standby");

  chk_standby_entry: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    !all_low ##1 all_low [*8] |-> !stby_r)
    else $error("standby entered too early");

  chk_rect_decay: assert property (@(posedge mclk_in)
    disable iff (!resetn_in)
    (!bridge_a_sync_rect_out || a_dec) && (!bridge_b_sync_rect_out || b_dec))
    else $error("rectifier on outside decay");

endmodule

//--- testbench/dbcc_ctl_model.sv
// External controller model driving both bridges' control pins
`timescale 1ns/100ps
module dbcc_ctl_model #(
  parameter int WAKE_CYC = 25
) (
  input  wire logic       mclk_in,
  input  wire logic       resetn_in,
  input  wire logic       standby_in,
  input  wire logic [1:0] cmd_a_in,
  input  wire logic [1:0] cmd_b_in,
  output logic            a_first_out,
  output logic            a_second_out,
  output logic            b_first_out,
  output logic            b_second_out
);
  int wake_cnt;

  ////////////////////////////////////////////////////////////////////////
  // Pins move only on the falling edge, away from the sampling edge
  always @(negedge mclk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      wake_cnt = 0;
      {a_first_out, a_second_out, b_first_out, b_second_out} = 4'h0;
    end
    else
    begin
      if (standby_in && ({cmd_a_in, cmd_b_in} != 4'h0) && wake_cnt == 0)
        wake_cnt = WAKE_CYC;
      if (wake_cnt > 0)
      begin
        // Wake with bridge a braking and bridge b coasting: no current flows while the pump settles
        wake_cnt = wake_cnt - 1;
        {a_first_out, a_second_out, b_first_out, b_second_out} = 4'hc;
      end
      else
        {a_first_out, a_second_out, b_first_out, b_second_out} =
          {cmd_a_in, cmd_b_in};
    end
  end
endmodule

//--- testbench/test_dual_bridge_chop_control.sv
// Self-checking bench for the dual bridge chop control block
`timescale 1ns/100ps
module test_dual_bridge_chop_control;
  localparam int OFF   = 40;
  localparam int FAST  = OFF * 50 / 100;
  localparam int DEAD  = 4;
  localparam int BLANK = 5;
  localparam int STBY  = 50;
  localparam int WAKE  = 25;

  logic       mclk_in = 1'b0;
  logic       resetn  = 1'b0;
  logic [1:0] cmd_a   = 2'h0;
  logic [1:0] cmd_b   = 2'h0;
  logic       trip_a  = 1'b0;
  logic       trip_b  = 1'b0;
  logic       zc_a    = 1'b0;
  logic       zc_b    = 1'b0;
  logic       sh_a    = 1'b0;
  logic       sh_b    = 1'b0;
  logic       hot     = 1'b0;
  logic       low     = 1'b0;
  logic [3:0] leg_a, leg_b;
  logic       sr_a, sr_b, pump, regen, stby;
  logic [1:0] fault;
  logic       pa_f, pa_s, pb_f, pb_s;
  int         errors  = 0;
  int         n_tests = 0;

  always #4 mclk_in = ~mclk_in;

  dbcc_ctl_model #(.WAKE_CYC(WAKE)) ctl (
    .mclk_in(mclk_in), .resetn_in(resetn), .standby_in(stby),
    .cmd_a_in(cmd_a), .cmd_b_in(cmd_b), .a_first_out(pa_f),
    .a_second_out(pa_s), .b_first_out(pb_f), .b_second_out(pb_s)
  );

  dbcc_top #(
    .OFF_CYC(OFF), .FAST_CYC(FAST), .DEAD_CYC(DEAD),
    .BLANK_CYC(BLANK), .STANDBY_CYC(STBY)
  ) dut (
    .mclk_in(mclk_in), .resetn_in(resetn),
    .bridge_a_ctl_first_in(pa_f), .bridge_a_ctl_second_in(pa_s),
    .bridge_b_ctl_first_in(pb_f), .bridge_b_ctl_second_in(pb_s),
    .bridge_a_trip_in(trip_a), .bridge_b_trip_in(trip_b),
    .bridge_a_zero_cur_in(zc_a), .bridge_b_zero_cur_in(zc_b),
    .bridge_a_short_in(sh_a), .bridge_b_short_in(sh_b),
    .over_temp_in(hot), .supply_low_lockout_in(low),
    .bridge_a_leg_first_out(leg_a[3]), .bridge_a_leg_first_oe_out(leg_a[2]),
    .bridge_a_leg_second_out(leg_a[1]),
    .bridge_a_leg_second_oe_out(leg_a[0]),
    .bridge_b_leg_first_out(leg_b[3]), .bridge_b_leg_first_oe_out(leg_b[2]),
    .bridge_b_leg_second_out(leg_b[1]),
    .bridge_b_leg_second_oe_out(leg_b[0]),
    .bridge_a_sync_rect_out(sr_a), .bridge_b_sync_rect_out(sr_b),
    .pump_enable_out(pump), .regulator_enable_out(regen),
    .standby_out(stby), .overcurrent_fault_latch_out(fault)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic check_vec(input logic [3:0] got, input logic [3:0] exp,
                           input string what);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic check_cnt(input int got, input int exp, input string what);
    n_tests++;
    if (got != exp)
    begin
      errors++;
      $display("BAD %0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk_in);
  endtask

  task automatic stop_test;
    $display("Checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Leg quads are {first, first_oe, second, second_oe}; mask 5 keeps oe
  task automatic t_table;
    logic [1:0] pat [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
    logic [3:0] exp [4] = '{4'hd, 4'h7, 4'h5, 4'h0};
    for (int i = 0; i < 4; i++)
    begin
      cmd_a <= pat[i];
      cmd_b <= pat[3 - i];
      cyc(8);
      check_vec(leg_a & (i == 3 ? 4'h5 : 4'hf), exp[i], "a");
      check_vec(leg_b & (i == 0 ? 4'h5 : 4'hf), exp[3 - i], "b");
    end
    $display("table test done");
  endtask

  task automatic t_trip;
    int n;
    cmd_a <= 2'h2;
    cmd_b <= 2'h1;
    trip_a <= 1'b1;
    cyc(6);
    check_vec(leg_a, 4'hd, "trip inside blanking");
    n = 0;
    while (sr_a !== 1'b1 && n < 20)
    begin
      cyc(1);
      n++;
    end
    check_vec({3'h0, sr_a}, 4'h1, "decay rectifies");
    trip_a <= 1'b0;
    n = 0;
    while (sr_a === 1'b1 && n < 100)
    begin
      cyc(1);
      n++;
    end
    check_cnt(n, FAST, "fast length");
    check_vec(leg_a & 4'h5, 4'h0, "dead drivers off");
    n = 0;
    while (sr_a !== 1'b1 && n < 20)
    begin
      cyc(1);
      n++;
    end
    check_cnt(n, DEAD, "dead length");
    check_vec(leg_a, 4'h5, "slow legs");
    check_vec(leg_b, 4'h7, "b keeps reverse");
    check_vec({3'h0, sr_b}, 4'h0, "b not rectifying");
    zc_a <= 1'b1;
    cyc(4);
    check_vec({3'h0, sr_a}, 4'h0, "zero current");
    zc_a <= 1'b0;
    n = 4;
    while (leg_a !== 4'hd && n < 60)
    begin
      cyc(1);
      n++;
    end
    check_cnt(n, OFF - FAST - DEAD, "slow length");
    $display("trip test done");
  endtask

  // Bridge b trips in reverse while bridge a keeps driving forward
  task automatic t_trip_b;
    int n;
    trip_b <= 1'b1;
    n = 0;
    while (sr_b !== 1'b1 && n < 20)
    begin
      cyc(1);
      n++;
    end
    check_vec(leg_b, 4'hd, "b fast decay");
    check_vec(leg_a, 4'hd, "a keeps forward");
    check_vec({3'h0, sr_a}, 4'h0, "a not rectifying");
    trip_b <= 1'b0;
    n = 0;
    while (leg_b !== 4'h7 && n < 100)
    begin
      cyc(1);
      n++;
    end
    check_cnt(n, OFF, "b off-time");
    $display("trip b test done");
  endtask

  task automatic t_flag(input bit sel);
    cmd_a <= 2'h2;
    cmd_b <= 2'h1;
    cyc(8);
    if (sel)
      low <= 1'b1;
    else
      hot <= 1'b1;
    cyc(5);
    check_vec((leg_a | leg_b) & 4'h5, 4'h0, "off");
    hot <= 1'b0;
    low <= 1'b0;
    cyc(6);
    check_vec(leg_a, 4'hd, "a back");
    check_vec(leg_b, 4'h7, "b back");
    $display("flag test done");
  endtask

  task automatic t_fault;
    int n;
    cmd_a <= 2'h2;
    cmd_b <= 2'h2;
    cyc(8);
    sh_a <= 1'b1;
    cyc(1);
    sh_a <= 1'b0;
    cyc(5);
    check_vec({2'h0, fault}, 4'h1, "fault a only");
    check_vec(leg_a & 4'h5, 4'h0, "faulted a off");
    check_vec(leg_b, 4'hd, "b unaffected");
    cmd_a <= 2'h1;
    cyc(8);
    check_vec({2'h0, fault}, 4'h1, "fault holds");
    cmd_a <= 2'h0;
    cmd_b <= 2'h0;
    cyc(STBY - 10);
    check_vec({3'h0, stby}, 4'h0, "standby early");
    n = 0;
    while (stby !== 1'b1 && n < 30)
    begin
      cyc(1);
      n++;
    end
    check_vec({1'b0, stby, pump, regen}, 4'h4, "standby");
    check_vec({2'h0, fault}, 4'h1, "fault in standby");
    // Model wakes with a brake and holds drive back
    cmd_a <= 2'h2;
    cyc(8);
    check_vec({stby, 1'b0, fault}, 4'h0, "woken, cleared");
    check_vec(leg_a, 4'h5, "wake brake");
    cyc(WAKE);
    check_vec(leg_a, 4'hd, "drive after wake");
    $display("fault test done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    cyc(8);
    resetn <= 1'b1;
    cyc(2);
    t_table;
    t_trip;
    t_trip_b;
    t_flag(1'b0);
    t_flag(1'b1);
    t_fault;
    stop_test;
  end

  // Whole run is some 280 cycles; seven times that means a hang
  initial
  begin
    cyc(2000);
    errors++;
    $display("BAD %0t watchdog expired", $time);
    stop_test;
  end
endmodule
